// ---- sram_core_pkg.sv ----
package sram_core_pkg;

  // data word and byte lane layout (x18 configuration)
  localparam int WORD_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int BURST_LEN = 4;
  localparam int BURST_W = WORD_W * BURST_LEN;

  // burst address width: 1M locations of four words
  localparam int ADDR_W = 20;
  localparam int DEPTH = 1 << ADDR_W;

  // read latency in half-cycle slots from the command slot
  localparam logic [2:0] LAT_SLOTS_LOOP_ON = 3'h3;
  localparam logic [2:0] LAT_SLOTS_LOOP_OFF = 3'h2;

  // slot pipeline lengths
  localparam int RD_PIPE_LEN = 5;
  localparam int WR_PIPE_LEN = 5;

  // first pipeline tap that captures write word 0
  localparam int WR_FIRST_TAP = 1;

  // pipeline tap that marks a command accepted on the previous k rise
  localparam int PREV_CMD_TAP = 1;

  // reset values
  localparam logic PHASE_RST = 1'b0;
  localparam logic [WORD_W-1:0] RD_DATA_RST = 18'h00000;

  // slot phase: positive input clock rise or its complement's rise
  typedef enum logic {
    SLOT_K_RISE = 1'b0,
    SLOT_KN_RISE = 1'b1
  } slot_phase_t;

endpackage

// ---- lane_merge.sv ----
`timescale 1ns/100ps
module lane_merge
  import sram_core_pkg::*;
(
  // stored word and incoming word
  input wire logic [WORD_W-1:0] old_word,
  input wire logic [WORD_W-1:0] new_word,
  // per-lane write enables, active high
  input wire logic [LANES-1:0] lane_en,
  // merged result
  output logic [WORD_W-1:0] merged_word
);

  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      // a deselected lane keeps what is stored
      merged_word[i*LANE_W +: LANE_W] = lane_en[i] ?
        new_word[i*LANE_W +: LANE_W] : old_word[i*LANE_W +: LANE_W];
    end
  end

endmodule // lane_merge

// ---- burst_sram_core.sv ----
`timescale 1ns/100ps
// What this block does
// - every access is four words over two cycles
// - loop enabled: read data after 1.5 cycles
// - loop disabled: read data after one cycle
// - accesses start only on positive clock rise
// - write data captured on both clock rises
// - read data launched from output registers
// - port and byte selects captured at clock rises
// - read select low latches the read address
// - read words leave in order, one per slot
// - read on the following rise is ignored
// - reads every other rise stream without gaps
// - deselected read port finishes, then floats outputs
// - write select low starts write burst
// - four write words follow the write command
// - full burst committed to array at once
// - write on the following rise is ignored
// - deselected write port finishes, then ignores inputs
// - selected bytes are written
// - deselected bytes keep their stored value
// - one shared address bus for both ports
// - both selects from idle: read goes, write is dropped
// - read after write forwards the pending data
// - powers up deselected with outputs floating
module burst_sram_core
  import sram_core_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // port selects and byte selects, active low
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic [sram_core_pkg::LANES-1:0] byte_write_select_n,
  // shared address and write data
  input wire logic [sram_core_pkg::ADDR_W-1:0] addr,
  input wire logic [sram_core_pkg::WORD_W-1:0] wr_data,
  // straps from pins
  input wire logic loop_disable_n,
  input wire logic out_clk_p_strap,
  input wire logic out_clk_n_strap,
  // slot phase marker for the controller
  output logic k_rise_slot,
  // read data and its output enable
  output logic [sram_core_pkg::WORD_W-1:0] rd_data,
  output logic rd_data_oe,
  // output timing reference taken from the input clock pair
  output logic single_clock_mode
);

  import sram_core_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // slot phase and strap sampling

  slot_phase_t phase_ff, nxt_phase;
  logic loop_meta_ff, loop_sync_ff;
  logic strap_p_meta_ff, strap_p_sync_ff;
  logic strap_n_meta_ff, strap_n_sync_ff;
  logic strap_done_ff, nxt_strap_done;
  logic single_ff, nxt_single;
  logic is_k_rise;

  assign is_k_rise = (phase_ff == SLOT_K_RISE);

  always_comb begin
    // each ref_clk cycle is one half of the input clock pair
    nxt_phase = (phase_ff == SLOT_K_RISE) ? SLOT_KN_RISE : SLOT_K_RISE;
    nxt_strap_done = 1'b1;
    nxt_single = single_ff;
    // the strap is caught once after release and never follows later
    if (!strap_done_ff) begin
      nxt_single = strap_p_sync_ff & strap_n_sync_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    loop_meta_ff <= loop_disable_n;
    loop_sync_ff <= loop_meta_ff;
    strap_p_meta_ff <= out_clk_p_strap;
    strap_p_sync_ff <= strap_p_meta_ff;
    strap_n_meta_ff <= out_clk_n_strap;
    strap_n_sync_ff <= strap_n_meta_ff;
    if (reset) begin
      phase_ff <= SLOT_K_RISE;
      strap_done_ff <= 1'b0;
      single_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      strap_done_ff <= nxt_strap_done;
      single_ff <= nxt_single;
    end
  end

  assign k_rise_slot = is_k_rise;
  // output and input clock pairs share edges in this model, so the mode
  // only changes which reference the words are timed to
  assign single_clock_mode = single_ff;

  ////////////////////////////////////////////////////////////////////////////
  // command acceptance and port arbitration

  logic [RD_PIPE_LEN-1:0] rd_sh_ff, nxt_rd_sh;
  logic [WR_PIPE_LEN-1:0] wr_sh_ff, nxt_wr_sh;
  logic rd_go, wr_go;
  logic rd_sel, wr_sel;

  always_comb begin
    // selects are only looked at on the positive rise
    rd_sel = is_k_rise & ~read_port_select_n;
    wr_sel = is_k_rise & ~write_port_select_n;
    // a read right after an accepted read is dropped
    rd_go = rd_sel & ~rd_sh_ff[PREV_CMD_TAP];
    // read wins a tie unless it was just refused
    wr_go = wr_sel & ~wr_sh_ff[PREV_CMD_TAP] & ~rd_go;
    nxt_rd_sh = {rd_sh_ff[RD_PIPE_LEN-2:0], rd_go};
    nxt_wr_sh = {wr_sh_ff[WR_PIPE_LEN-2:0], wr_go};
  end

  ////////////////////////////////////////////////////////////////////////////
  // write burst collection

  logic [ADDR_W-1:0] wr_cmd_addr_ff, nxt_wr_cmd_addr;
  logic [ADDR_W-1:0] wr_buf_addr_ff, nxt_wr_buf_addr;
  logic [WORD_W-1:0] wr_buf_ff [BURST_LEN];
  logic [WORD_W-1:0] nxt_wr_buf [BURST_LEN];
  logic [LANES-1:0] wr_be_ff [BURST_LEN];
  logic [LANES-1:0] nxt_wr_be [BURST_LEN];
  logic [BURST_LEN-1:0] wr_got_ff, nxt_wr_got;
  logic commit;

  always_comb begin
    nxt_wr_cmd_addr = wr_cmd_addr_ff;
    nxt_wr_buf_addr = wr_buf_addr_ff;
    nxt_wr_got = wr_got_ff;
    commit = 1'b0;
    for (int i = 0; i < BURST_LEN; i++) begin
      nxt_wr_buf[i] = wr_buf_ff[i];
      nxt_wr_be[i] = wr_be_ff[i];
    end
    if (wr_go) begin
      nxt_wr_cmd_addr = addr;
    end
    for (int i = 0; i < BURST_LEN; i++) begin
      // word i arrives i slots after the k rise that follows the command
      if (wr_sh_ff[WR_FIRST_TAP + i]) begin
        nxt_wr_buf[i] = wr_data;
        nxt_wr_be[i] = ~byte_write_select_n;
        nxt_wr_got[i] = 1'b1;
      end
    end
    if (wr_sh_ff[WR_FIRST_TAP]) begin
      // next command may already overwrite the command address
      nxt_wr_buf_addr = wr_cmd_addr_ff;
      nxt_wr_got = {{(BURST_LEN-1){1'b0}}, 1'b1};
    end
    if (wr_sh_ff[WR_FIRST_TAP + BURST_LEN - 1]) begin
      commit = 1'b1;
      nxt_wr_got = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory array and commit merge

  logic [BURST_W-1:0] mem [DEPTH];
  logic [BURST_W-1:0] commit_old;
  logic [BURST_W-1:0] commit_word;

  assign commit_old = mem[wr_buf_addr_ff];

  for (genvar g = 0; g < BURST_LEN; g++) begin : g_commit
    lane_merge u_merge (
      .old_word(commit_old[g*WORD_W +: WORD_W]),
      // the last word goes straight from the pins to avoid a slot of delay
      .new_word((g == BURST_LEN-1) ? wr_data : wr_buf_ff[g]),
      .lane_en((g == BURST_LEN-1) ? ~byte_write_select_n : wr_be_ff[g]),
      .merged_word(commit_word[g*WORD_W +: WORD_W])
    );
  end

  // array has no reset; contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (commit) begin
      mem[wr_buf_addr_ff] <= commit_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read word selection and forwarding

  logic [ADDR_W-1:0] rd_addr_ff, nxt_rd_addr;
  logic [ADDR_W-1:0] rd_burst_addr_ff, nxt_rd_burst_addr;
  logic [WORD_W-1:0] rd_data_ff, nxt_rd_data;
  logic rd_oe_ff, nxt_rd_oe;
  logic [1:0] ld_idx;
  logic ld_any;
  logic ld_base;
  logic [ADDR_W-1:0] ld_addr;
  logic [BURST_W-1:0] ld_burst;
  logic [WORD_W-1:0] ld_mem_word;
  logic [WORD_W-1:0] ld_fwd_word;
  logic fwd_hit;

  always_comb begin
    // loop on adds one slot of latency
    ld_base = loop_sync_ff;
    ld_any = 1'b0;
    ld_idx = 2'h0;
    for (int i = 0; i < BURST_LEN; i++) begin
      // spaced reads never overlap in this window
      if (rd_sh_ff[int'(ld_base) + i]) begin
        ld_any = 1'b1;
        ld_idx = 2'(i);
      end
    end
    ld_addr = (ld_idx == 2'h0) ? rd_addr_ff : rd_burst_addr_ff;
  end

  assign ld_burst = mem[ld_addr];
  assign ld_mem_word = ld_burst[ld_idx*WORD_W +: WORD_W];
  // pending write to the same location overrides the array
  assign fwd_hit = (|wr_got_ff) & wr_got_ff[ld_idx]
    & (wr_buf_addr_ff == ld_addr);

  lane_merge u_fwd (
    .old_word(ld_mem_word),
    .new_word(wr_buf_ff[ld_idx]),
    .lane_en(fwd_hit ? wr_be_ff[ld_idx] : {LANES{1'b0}}),
    .merged_word(ld_fwd_word)
  );

  always_comb begin
    nxt_rd_addr = rd_addr_ff;
    nxt_rd_burst_addr = rd_burst_addr_ff;
    nxt_rd_data = rd_data_ff;
    if (rd_go) begin
      nxt_rd_addr = addr;
    end
    if (ld_any && ld_idx == 2'h0) begin
      // a following read may replace the command address mid burst
      nxt_rd_burst_addr = rd_addr_ff;
    end
    if (ld_any) begin
      nxt_rd_data = ld_fwd_word;
    end
    // float once the last pending word has been shown
    nxt_rd_oe = ld_any;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_sh_ff <= '0;
      wr_sh_ff <= '0;
      rd_addr_ff <= '0;
      rd_burst_addr_ff <= '0;
      rd_data_ff <= RD_DATA_RST;
      rd_oe_ff <= 1'b0;
      wr_cmd_addr_ff <= '0;
      wr_buf_addr_ff <= '0;
      wr_got_ff <= '0;
      for (int i = 0; i < BURST_LEN; i++) begin
        wr_buf_ff[i] <= '0;
        wr_be_ff[i] <= '0;
      end
    end else begin
      rd_sh_ff <= nxt_rd_sh;
      wr_sh_ff <= nxt_wr_sh;
      rd_addr_ff <= nxt_rd_addr;
      rd_burst_addr_ff <= nxt_rd_burst_addr;
      rd_data_ff <= nxt_rd_data;
      rd_oe_ff <= nxt_rd_oe;
      wr_cmd_addr_ff <= nxt_wr_cmd_addr;
      wr_buf_addr_ff <= nxt_wr_buf_addr;
      wr_got_ff <= nxt_wr_got;
      for (int i = 0; i < BURST_LEN; i++) begin
        wr_buf_ff[i] <= nxt_wr_buf[i];
        wr_be_ff[i] <= nxt_wr_be[i];
      end
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_data_oe = rd_oe_ff;

endmodule // burst_sram_core

// ---- sram_core_props.sv ----
`timescale 1ns/100ps
module sram_core_props
  import sram_core_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // watched pins
  input wire logic read_port_select_n,
  input wire logic loop_disable_n,
  input wire logic k_rise_slot,
  input wire logic rd_data_oe,
  input wire logic single_clock_mode
);
  logic rd_acc;
  logic [1:0] acc_ff;
  logic [1:0] nxt_acc;
  // a read one k rise after an accepted read is not counted
  assign rd_acc = k_rise_slot && !read_port_select_n && !acc_ff[1];
  always_comb nxt_acc = reset ? 2'h0 : {acc_ff[0], rd_acc};
  always_ff @(posedge ref_clk) acc_ff <= nxt_acc;
  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // loop input steady long enough to pass its synchroniser
  sequence s_rd_on;
    rd_acc && loop_disable_n && $past(loop_disable_n, 3);
  endsequence
  sequence s_rd_off;
    rd_acc && !loop_disable_n && !$past(loop_disable_n, 3);
  endsequence
  a_lat_on: assert property (s_rd_on |-> ##3 rd_data_oe [*4])
    else $error("loop on burst wrong");
  a_lat_off: assert property (s_rd_off |-> ##2 rd_data_oe [*4])
    else $error("loop off burst wrong");
  a_oe_cause: assert property ($rose(rd_data_oe) |->
    $past(rd_acc, 2) || $past(rd_acc, 3)) else $error("oe without read");
  a_oe_drop: assert property (
    s_rd_on ##1 (!rd_acc) [*5] |-> ##2 !rd_data_oe)
    else $error("outputs not floated");
  // two spaced reads cover eight slots from the first word on
  a_stream: assert property (
    s_rd_on ##4 rd_acc |-> $past(rd_data_oe) && rd_data_oe
    ##1 rd_data_oe [*6]) else $error("gap");
  a_phase_alt: assert property (
    k_rise_slot |=> !k_rise_slot ##1 k_rise_slot) else $error("phase");
  a_rst_idle: assert property (
    $fell(reset) |-> k_rise_slot && !rd_data_oe) else $error("not idle");
  a_strap_hold: assert property (
    !$past(reset) && !$past(reset, 2) |-> $stable(single_clock_mode))
    else $error("strap result moved");
endmodule // sram_core_props

// ---- mem_ctrl_model.sv ----
`timescale 1ns/100ps
module mem_ctrl_model
  import sram_core_pkg::*;
(
  // clock and slot marker
  input wire logic ref_clk,
  input wire logic k_rise_slot,
  // controls and data towards the core
  output logic read_port_select_n,
  output logic write_port_select_n,
  output logic [sram_core_pkg::LANES-1:0] byte_write_select_n,
  output logic [sram_core_pkg::ADDR_W-1:0] addr,
  output logic [sram_core_pkg::WORD_W-1:0] wr_data
);
  initial begin
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    byte_write_select_n = 2'h3;
    addr = 20'h00000;
    wr_data = 18'h00000;
  end
  //////////////////////////////////////////////////////////////////////////
  // no spacing here, so callers can break it on purpose
  task automatic cmd(input logic rn, input logic wn,
                     input logic [ADDR_W-1:0] a);
    do @(negedge ref_clk); while (k_rise_slot);
    @(posedge ref_clk);
    read_port_select_n <= rn;
    write_port_select_n <= wn;
    addr <= a;
    @(posedge ref_clk);
    read_port_select_n <= 1'b1;
    write_port_select_n <= 1'b1;
    addr <= ~a; // released bus does not keep its value
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    cmd(1'b0, 1'b1, a);
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a,
                    input logic [BURST_W-1:0] d, input logic [7:0] b);
    cmd(1'b1, 1'b0, a);
    for (int i = 0; i < BURST_LEN; i++) begin
      @(posedge ref_clk);
      wr_data <= d[i*WORD_W +: WORD_W];
      byte_write_select_n <= b[i*LANES +: LANES];
    end
    @(posedge ref_clk);
    wr_data <= ~d[BURST_W-1 -: WORD_W];
    byte_write_select_n <= 2'h3;
  endtask
endmodule // mem_ctrl_model

// ---- burst_sram_core_test.sv ----
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end
module burst_sram_core_test;
  import sram_core_pkg::*;
  logic ref_clk, reset, loop_disable_n, k_rise_slot, rd_data_oe, scm;
  logic rps_n, wps_n;
  logic [LANES-1:0] bws_n;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] wr_data, rd_data, exp_w;
  logic [BURST_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [WORD_W-1:0] exp_q [$];
  int n_errors = 0;
  int num_checks = 0;
  int seed;
  burst_sram_core u_dut (.ref_clk(ref_clk), .reset(reset),
    .read_port_select_n(rps_n), .write_port_select_n(wps_n),
    .byte_write_select_n(bws_n), .addr(addr), .wr_data(wr_data),
    .loop_disable_n(loop_disable_n), .out_clk_p_strap(1'b1),
    .out_clk_n_strap(1'b1), .k_rise_slot(k_rise_slot),
    .rd_data(rd_data), .rd_data_oe(rd_data_oe), .single_clock_mode(scm));
  mem_ctrl_model u_ctl (.ref_clk(ref_clk), .k_rise_slot(k_rise_slot),
    .read_port_select_n(rps_n), .write_port_select_n(wps_n),
    .byte_write_select_n(bws_n), .addr(addr), .wr_data(wr_data));
  always #50 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic push(input logic [ADDR_W-1:0] a);
    for (int i = 0; i < BURST_LEN; i++)
      exp_q.push_back(mem[a][i*WORD_W +: WORD_W]);
  endtask
  task automatic do_rd(input logic [ADDR_W-1:0] a);
    push(a);
    u_ctl.rd(a);
  endtask
  // first write of a place must fill every lane, the array starts unknown
  task automatic do_wr(input logic [ADDR_W-1:0] a, input logic full);
    logic [BURST_W-1:0] d;
    logic [7:0] b;
    d = BURST_W'({$urandom(), $urandom(), $urandom()});
    b = full ? 8'h00 : 8'($urandom());
    for (int i = 0; i < 8; i++)
      if (!b[i]) mem[a][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
    u_ctl.wr(a, d, b);
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(negedge ref_clk) begin
    if (rd_data_oe === 1'b1) begin
      exp_w = exp_q.size() ? exp_q.pop_front() : 18'h3FFFF;
      `CHK(rd_data, exp_w)
    end
  end
  initial begin
    #(3000 * 100);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    loop_disable_n = 1'b1;
    seed = $urandom(32'h25FF6AF0);
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(rd_data_oe, 1'b0)
    `CHK(scm, 1'b1)
    for (int i = 0; i < 6; i++) do_wr(20'(i * 3), 1'b1);
    for (int i = 0; i < 6; i++) do_wr(20'(i * 3), 1'b0);
    for (int i = 0; i < 6; i++) do_rd(20'(i * 3));
    push(20'h00000);
    u_ctl.cmd(1'b0, 1'b1, 20'h00000);
    u_ctl.cmd(1'b0, 1'b1, 20'h00003);
    repeat (10) @(posedge ref_clk);
    push(20'h00006);
    u_ctl.cmd(1'b0, 1'b0, 20'h00006);
    repeat (10) @(posedge ref_clk);
    do_rd(20'h00006);
    for (int i = 0; i < 3; i++) begin
      fork
        do_wr(20'h00009, 1'(i == 0));
        begin
          @(negedge wps_n);
          do_rd(20'h00009);
        end
      join
    end
    loop_disable_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) do_rd(20'(i * 3));
    repeat (12) @(posedge ref_clk);
    `CHK(exp_q.size(), 0)
    end_sim();
  end
endmodule // burst_sram_core_test
bind burst_sram_core sram_core_props u_props (.ref_clk(ref_clk),
  .reset(reset), .read_port_select_n(read_port_select_n),
  .loop_disable_n(loop_disable_n), .k_rise_slot(k_rise_slot),
  .rd_data_oe(rd_data_oe), .single_clock_mode(single_clock_mode));
